// [lprs_defs.vh]
// register map, field positions, reset values and timing counts for the low-power reset/status unit
`ifndef LPRS_DEFS_VH
`define LPRS_DEFS_VH

// register byte offsets
`define LPRS_OFF_BRK_WAIT    8'h00
`define LPRS_OFF_RST_SRC     8'h04
`define LPRS_OFF_BRK_FLAG    8'h08
`define LPRS_OFF_SYS_CFG     8'h0C
`define LPRS_OFF_MODE        8'h10

// break_wait_status fields
`define LPRS_BIT_BREAK_WAIT  0

// reset_source_status fields
`define LPRS_BIT_POWER_ON    7
`define LPRS_BIT_PIN_RESET   6
`define LPRS_BIT_WDOG_RESET  5
`define LPRS_BIT_BAD_OPCODE  4
`define LPRS_BIT_BAD_ADDRESS 3
`define LPRS_BIT_LOW_VOLTAGE 1

// break_flag_control fields
`define LPRS_BIT_CLEAR_EN    7

// sys_config fields
`define LPRS_BIT_SHORT_REC   0
`define LPRS_BIT_WDOG_DIS    1

// reset values
`define LPRS_RST_BRK_WAIT    1'b0
`define LPRS_RST_RST_SRC     6'h00
`define LPRS_RST_CLEAR_EN    1'b0
`define LPRS_RST_SHORT_REC   1'b0
`define LPRS_RST_WDOG_DIS    1'b0

// timing counts, in crystal_clock cycles
`define LPRS_SHORT_RECOVERY  32
`define LPRS_LONG_RECOVERY   4096
`define LPRS_RESET_EXIT_DLY  64
// system clocks per crystal_clock period
`define LPRS_XCLK_DIV        4

`endif

// [lprs_xclk_div.v]
// crystal_clock falling-edge enable generator
`timescale 1ns/1ps
`default_nettype none

module lprs_xclk_div #(
	parameter integer DIV = 4
) (
	input  wire clk_i,
	input  wire rst_n_i,
	output reg  fall_o
);

	reg [15:0] div_reg;

	// one-cycle pulse stands for each falling edge of crystal_clock
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_reg <= 16'h0000;
			fall_o  <= 1'b0;
		end else if (div_reg == DIV[15:0] - 16'h0001) begin
			div_reg <= 16'h0000;
			fall_o  <= 1'b1;
		end else begin
			div_reg <= div_reg + 16'h0001;
			fall_o  <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// [lprs_recov_cnt.v]
// 12-bit recovery counter advanced by crystal_clock falling edges
`timescale 1ns/1ps
`default_nettype none

module lprs_recov_cnt #(
	parameter integer WIDTH = 12
) (
	input  wire             clk_i,
	input  wire             rst_n_i,
	input  wire             clear_i,
	input  wire             tick_i,
	output reg  [WIDTH-1:0] count_o
);

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			count_o <= {WIDTH{1'b0}};
		end else if (clear_i) begin
			count_o <= {WIDTH{1'b0}};
		end else if (tick_i) begin
			count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

`default_nettype wire

// [lprs_top.v]
// low-power sequencing, clock gating and status registers of the system integration unit
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lprs_defs.vh"

module lprs_top #(
	parameter integer CNT_WIDTH   = 12,
	parameter integer XCLK_DIV    = `LPRS_XCLK_DIV,
	parameter integer SHORT_REC   = `LPRS_SHORT_RECOVERY,
	parameter integer LONG_REC    = `LPRS_LONG_RECOVERY,
	parameter integer RST_EXIT    = `LPRS_RESET_EXIT_DLY
) (
	input  wire        clk_i,
	input  wire        rst_n_i,
	// apb slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	// processor side
	input  wire        wait_exec_i,
	input  wire        stop_exec_i,
	input  wire        module_irq_i,
	input  wire        break_irq_i,
	input  wire        break_state_i,
	// reset sources, one-cycle pulses
	input  wire        power_on_i,
	input  wire        pin_reset_i,
	input  wire        wdog_timeout_i,
	input  wire        bad_opcode_i,
	input  wire        bad_fetch_addr_i,
	input  wire        low_voltage_i,
	// control outputs
	output reg         imask_clear_o,
	output reg         cpu_clk_en_o,
	output reg         periph_clk_en_o,
	output reg         base_clock_out_en_o,
	output reg         crystal_clock_en_o,
	output reg         stack_start_o,
	output reg         vector_fetch_o,
	output reg         break_active_o,
	output reg         wdog_run_o,
	output reg         status_clear_ok_o
);

	////////////////////////////////////////////////////////////////////////////////
	// states and helpers

	localparam [2:0] ST_RUN   = 3'h0;
	localparam [2:0] ST_WAIT  = 3'h1;
	localparam [2:0] ST_STOP  = 3'h2;
	localparam [2:0] ST_RECOV = 3'h3;
	localparam [2:0] ST_RDLY  = 3'h4;

	// true at the tick that completes the given number of crystal periods
	function reached;
		input [CNT_WIDTH-1:0] cnt;
		input [CNT_WIDTH:0]   target;
		begin
			reached = ({1'b0, cnt} == target - {{CNT_WIDTH{1'b0}}, 1'b1});
		end
	endfunction

	reg  [2:0]           state_reg;
	reg  [2:0]           state_next;
	reg                  by_reset_reg;
	reg                  by_reset_next;
	reg                  break_wait_reg;
	reg                  break_wait_next;
	reg  [5:0]           rst_src_reg;
	reg  [5:0]           rst_src_next;
	reg                  clear_en_reg;
	reg                  short_rec_reg;
	reg                  wdog_dis_reg;
	reg                  cnt_clear;
	reg                  stack_next;
	reg                  vector_next;
	wire                 xclk_fall;
	wire [CNT_WIDTH-1:0] rec_count;
	wire                 any_reset;
	wire                 clear_allowed;
	wire                 apb_setup;
	wire                 apb_done;
	wire                 apb_wr;
	wire                 apb_rd;
	wire [CNT_WIDTH:0]   rec_target;

	////////////////////////////////////////////////////////////////////////////////
	// crystal clock enable and recovery counter

	lprs_xclk_div #(
		.DIV (XCLK_DIV)
	) u_div (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.fall_o  (xclk_fall)
	);

	lprs_recov_cnt #(
		.WIDTH (CNT_WIDTH)
	) u_cnt (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.clear_i (cnt_clear),
		.tick_i  (xclk_fall),
		.count_o (rec_count)
	);

	// the oscillator keeps running for the divider: only the outputs are gated in stop
	assign rec_target = short_rec_reg ? SHORT_REC[CNT_WIDTH:0] : LONG_REC[CNT_WIDTH:0];

	assign any_reset = power_on_i | pin_reset_i | wdog_timeout_i |
	                   bad_opcode_i | bad_fetch_addr_i | low_voltage_i;

	// status flags may only be cleared by software outside break, or inside it with the enable set; a reset source clears them in either case
	assign clear_allowed = !break_state_i || clear_en_reg;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode: one wait-free access, pready raised after the setup cycle

	assign apb_setup = psel_i && !penable_i;
	assign apb_done  = psel_i && penable_i && pready_o;
	assign apb_wr    = apb_done && pwrite_i;
	assign apb_rd    = apb_done && !pwrite_i;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	always @* begin
		state_next    = state_reg;
		by_reset_next = by_reset_reg;
		cnt_clear     = 1'b0;
		stack_next    = 1'b0;
		vector_next   = 1'b0;
		case (state_reg)
		ST_RUN: begin
			if (any_reset) begin
				state_next = ST_RUN;
			end else if (stop_exec_i) begin
				state_next = ST_STOP;
				cnt_clear  = 1'b1;
			end else if (wait_exec_i) begin
				state_next = ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (any_reset) begin
				state_next = ST_RDLY;
				cnt_clear  = 1'b1;
			end else if (break_irq_i || module_irq_i) begin
				state_next = ST_RUN;
				stack_next = 1'b1;
			end
		end
		ST_STOP: begin
			cnt_clear = 1'b1;
			if (any_reset || module_irq_i) begin
				state_next    = ST_RECOV;
				by_reset_next = any_reset;
			end
		end
		ST_RECOV: begin
			if (any_reset) begin
				by_reset_next = 1'b1;
			end
			if (xclk_fall && reached(rec_count, rec_target)) begin
				state_next  = ST_RUN;
				stack_next  = !(by_reset_reg || any_reset);
				vector_next = by_reset_reg || any_reset;
				cnt_clear   = 1'b1;
			end
		end
		ST_RDLY: begin
			if (xclk_fall && reached(rec_count, RST_EXIT[CNT_WIDTH:0])) begin
				state_next  = ST_RUN;
				vector_next = 1'b1;
				cnt_clear   = 1'b1;
			end
		end
		default: begin
			state_next = ST_RUN;
		end
		endcase
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg    <= ST_RUN;
			by_reset_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			by_reset_reg <= by_reset_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status flags

	always @* begin
		break_wait_next = break_wait_reg;
		if (apb_wr && paddr_i == `LPRS_OFF_BRK_WAIT && !pwdata_i[`LPRS_BIT_BREAK_WAIT] && clear_allowed) begin
			break_wait_next = 1'b0;
		end
		if (any_reset) begin
			break_wait_next = 1'b0;
		end
		// a break ending wait in the same cycle as a clear still leaves the flag set
		if (state_reg == ST_WAIT && break_irq_i && !any_reset) begin
			break_wait_next = 1'b1;
		end
	end

	always @* begin
		rst_src_next = rst_src_reg;
		if (apb_rd && paddr_i == `LPRS_OFF_RST_SRC && clear_allowed) begin
			rst_src_next = 6'h00;
		end
		if (power_on_i) begin
			rst_src_next = 6'h20;
		end else if (any_reset) begin
			rst_src_next = {1'b0, pin_reset_i, wdog_timeout_i, bad_opcode_i,
			                bad_fetch_addr_i, low_voltage_i};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers and apb answer

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			break_wait_reg <= `LPRS_RST_BRK_WAIT;
			rst_src_reg    <= `LPRS_RST_RST_SRC;
			clear_en_reg   <= `LPRS_RST_CLEAR_EN;
			short_rec_reg  <= `LPRS_RST_SHORT_REC;
			wdog_dis_reg   <= `LPRS_RST_WDOG_DIS;
		end else begin
			break_wait_reg <= break_wait_next;
			rst_src_reg    <= rst_src_next;
			if (apb_wr && paddr_i == `LPRS_OFF_BRK_FLAG) begin
				clear_en_reg <= pwdata_i[`LPRS_BIT_CLEAR_EN];
			end
			// configuration is sampled by recovery when it ends, so a write mid-stop takes effect
			if (apb_wr && paddr_i == `LPRS_OFF_SYS_CFG) begin
				short_rec_reg <= pwdata_i[`LPRS_BIT_SHORT_REC];
				wdog_dis_reg  <= pwdata_i[`LPRS_BIT_WDOG_DIS];
			end
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o <= apb_setup;
			if (apb_setup) begin
				pslverr_o <= 1'b0;
				prdata_o  <= 32'h00000000;
				case (paddr_i)
				`LPRS_OFF_BRK_WAIT: begin
					prdata_o[`LPRS_BIT_BREAK_WAIT] <= break_wait_reg;
				end
				`LPRS_OFF_RST_SRC: begin
					prdata_o[7:0] <= {rst_src_reg[5:1], 1'b0, rst_src_reg[0], 1'b0};
				end
				`LPRS_OFF_BRK_FLAG: begin
					prdata_o[`LPRS_BIT_CLEAR_EN] <= clear_en_reg;
				end
				`LPRS_OFF_SYS_CFG: begin
					prdata_o[`LPRS_BIT_SHORT_REC] <= short_rec_reg;
					prdata_o[`LPRS_BIT_WDOG_DIS]  <= wdog_dis_reg;
				end
				`LPRS_OFF_MODE: begin
					prdata_o[2:0] <= state_reg;
				end
				default: begin
					pslverr_o <= 1'b1;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered control outputs

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			imask_clear_o       <= 1'b0;
			cpu_clk_en_o        <= 1'b1;
			periph_clk_en_o     <= 1'b1;
			base_clock_out_en_o <= 1'b1;
			crystal_clock_en_o  <= 1'b1;
			stack_start_o       <= 1'b0;
			vector_fetch_o      <= 1'b0;
			break_active_o      <= 1'b1;
			wdog_run_o          <= 1'b0;
			status_clear_ok_o   <= 1'b1;
		end else begin
			imask_clear_o       <= state_reg == ST_RUN && !any_reset &&
			                       (wait_exec_i || stop_exec_i);
			cpu_clk_en_o        <= state_next == ST_RUN;
			periph_clk_en_o     <= state_next == ST_RUN || state_next == ST_WAIT ||
			                       state_next == ST_RDLY;
			base_clock_out_en_o <= state_next != ST_STOP && state_next != ST_RECOV;
			crystal_clock_en_o  <= state_next != ST_STOP && state_next != ST_RECOV;
			stack_start_o       <= stack_next;
			vector_fetch_o      <= vector_next;
			break_active_o      <= state_next != ST_STOP;
			wdog_run_o          <= !wdog_dis_reg && state_next != ST_STOP &&
			                       state_next != ST_RECOV;
			status_clear_ok_o   <= clear_allowed;
		end
	end

endmodule

`default_nettype wire

// [lprs_properties.sv]
// port-level assertions for the low-power reset/status unit
`timescale 1ns/1ps
`default_nettype none
module lprs_props #(
	parameter integer XCLK_DIV  = 4,
	parameter integer SHORT_REC = 32,
	parameter integer LONG_REC  = 4096
) (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       psel_i,
	input wire logic       penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic       pready_o,
	input wire logic       pslverr_o,
	input wire logic       wait_exec_i,
	input wire logic       stop_exec_i,
	input wire logic       module_irq_i,
	input wire logic       break_irq_i,
	input wire logic       break_state_i,
	input wire logic       imask_clear_o,
	input wire logic       cpu_clk_en_o,
	input wire logic       periph_clk_en_o,
	input wire logic       base_clock_out_en_o,
	input wire logic       crystal_clock_en_o,
	input wire logic       stack_start_o,
	input wire logic       vector_fetch_o,
	input wire logic       break_active_o,
	input wire logic       status_clear_ok_o
);
	// late end allows two divider periods plus register stages
	localparam int LIM    = LONG_REC * XCLK_DIV + 2 * XCLK_DIV + 4;
	localparam int MINOFF = SHORT_REC * XCLK_DIV - XCLK_DIV;
	int off_cnt;
	int wake_cnt;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || crystal_clock_en_o)
			off_cnt <= 0;
		else
			off_cnt <= off_cnt + 1;
	end
	// full-length recovery is far too long for a delay range, so count it
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || crystal_clock_en_o)
			wake_cnt <= 0;
		else if (wake_cnt > 0 || module_irq_i)
			wake_cnt <= wake_cnt + 1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////////////
	property p_wait_in;
		wait_exec_i && cpu_clk_en_o && crystal_clock_en_o |=> imask_clear_o && !cpu_clk_en_o;
	endproperty
	a_wait_in: assert property (p_wait_in) else $error("wait entry wrong");
	property p_stop_in;
		stop_exec_i && cpu_clk_en_o && crystal_clock_en_o |=>
			imask_clear_o && !base_clock_out_en_o && !crystal_clock_en_o && !periph_clk_en_o && !break_active_o;
	endproperty
	a_stop_in: assert property (p_stop_in) else $error("stop entry wrong");
	property p_wait_clk;
		!cpu_clk_en_o && base_clock_out_en_o |-> periph_clk_en_o;
	endproperty
	a_wait_clk: assert property (p_wait_clk) else $error("peripheral clock off in wait");
	property p_wake;
		(module_irq_i || break_irq_i) && !cpu_clk_en_o && crystal_clock_en_o |=> stack_start_o && cpu_clk_en_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wait wake late");
	property p_rec_end;
		$rose(crystal_clock_en_o) |-> (stack_start_o || vector_fetch_o) && off_cnt >= MINOFF;
	endproperty
	a_rec_end: assert property (p_rec_end) else $error("stop recovery end wrong");
	property p_rec_max;
		wake_cnt <= LIM;
	endproperty
	a_rec_max: assert property (p_rec_max) else $error("stop recovery too long");
	property p_clr;
		!break_state_i |=> status_clear_ok_o;
	endproperty
	a_clr: assert property (p_clr) else $error("clear not allowed outside break");
	property p_rdy;
		psel_i && !penable_i |=> pready_o && $stable(paddr_i);
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_err;
		pready_o && paddr_i > 8'h10 |-> pslverr_o;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not flagged");
endmodule
bind lprs_top lprs_props #(.XCLK_DIV(XCLK_DIV), .SHORT_REC(SHORT_REC), .LONG_REC(LONG_REC)) u_props (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .wait_exec_i(wait_exec_i), .stop_exec_i(stop_exec_i),
	.module_irq_i(module_irq_i), .break_irq_i(break_irq_i), .break_state_i(break_state_i),
	.imask_clear_o(imask_clear_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
	.base_clock_out_en_o(base_clock_out_en_o), .crystal_clock_en_o(crystal_clock_en_o),
	.stack_start_o(stack_start_o), .vector_fetch_o(vector_fetch_o), .break_active_o(break_active_o),
	.status_clear_ok_o(status_clear_ok_o));
`default_nettype wire

// [lprs_cpu_model.sv]
// processor core stand-in driving instruction and wake events
`timescale 1ns/1ps
`default_nettype none
module lprs_cpu_model (
	input  wire logic clk_i,
	output wire logic wait_exec_o,
	output wire logic stop_exec_o,
	output wire logic module_irq_o,
	output wire logic break_irq_o,
	output var  logic break_state_o
);
	logic [3:0] ev = 4'h0;
	initial break_state_o = 1'b0;
	assign wait_exec_o  = ev[0];
	assign stop_exec_o  = ev[1];
	assign module_irq_o = ev[2];
	assign break_irq_o  = ev[3];
	// one event per instruction cycle, dropped after one clock
	task automatic pulse(input int k);
		@(posedge clk_i);
		ev <= 4'h1 << k;
		@(posedge clk_i);
		ev <= 4'h0;
	endtask
	task automatic brk(input logic v);
		@(posedge clk_i);
		break_state_o <= v;
	endtask
endmodule
`default_nettype wire

// [lprs_tb.sv]
// self-checking bench for the low-power reset/status unit
`timescale 1ns/1ps
`default_nettype none
`include "lprs_defs.vh"
module tb;
	// shortened long counts keep the run brief
	localparam integer DIV = 2;
	localparam integer LREC = 64;
	localparam integer REXIT = 8;
	localparam logic [7:0] A_BW = `LPRS_OFF_BRK_WAIT;
	localparam logic [7:0] A_RS = `LPRS_OFF_RST_SRC;
	localparam logic [7:0] A_BF = `LPRS_OFF_BRK_FLAG;
	localparam logic [7:0] A_CF = `LPRS_OFF_SYS_CFG;
	logic        clk_i = 1'b0;
	logic        rst_n_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i;
	logic [5:0]  rs;
	logic [31:0] rd;
	logic        err;
	wire  [31:0] prdata_o;
	wire         pready_o, pslverr_o, wx, sx, mi, bi, bs;
	wire         imask, cpu_en, per_en, base_en, xtal_en, stack, vfetch, brk_act, wdog, clr_ok;
	int          num_errors = 0;
	int          cmp_count = 0;
	always #5 clk_i = ~clk_i;
	lprs_top #(.XCLK_DIV(DIV), .LONG_REC(LREC), .RST_EXIT(REXIT)) dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.wait_exec_i(wx), .stop_exec_i(sx), .module_irq_i(mi), .break_irq_i(bi), .break_state_i(bs),
		.power_on_i(rs[5]), .pin_reset_i(rs[4]), .wdog_timeout_i(rs[3]), .bad_opcode_i(rs[2]),
		.bad_fetch_addr_i(rs[1]), .low_voltage_i(rs[0]), .imask_clear_o(imask), .cpu_clk_en_o(cpu_en),
		.periph_clk_en_o(per_en), .base_clock_out_en_o(base_en), .crystal_clock_en_o(xtal_en),
		.stack_start_o(stack), .vector_fetch_o(vfetch), .break_active_o(brk_act), .wdog_run_o(wdog),
		.status_clear_ok_o(clr_ok));
	lprs_cpu_model cpu (.clk_i(clk_i), .wait_exec_o(wx), .stop_exec_o(sx), .module_irq_o(mi),
		.break_irq_o(bi), .break_state_o(bs));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		// a slave that never answers is a mismatch, not a silent pass
		if (pready_o !== 1'b1)
			num_errors++;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask
	task automatic rpulse(input logic [5:0] m);
		@(posedge clk_i);
		rs <= m;
		@(posedge clk_i);
		rs <= 6'h00;
	endtask
	// bounded wait for stacking (sel 0) or vector fetch (sel 1)
	task automatic waitfor(input logic sel, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((sel ? vfetch : stack) !== 1'b1 && n < 400);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rdchk("bw reset", A_BW, 32'h0);
		rdchk("src reset", A_RS, 32'h0);
		rdchk("mode reset", `LPRS_OFF_MODE, 32'h0);
		apb(1'b1, A_BF, 32'hFFFFFFFF);
		rdchk("flag ctl", A_BF, 32'h80);
		apb(1'b1, A_BF, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
	endtask
	task automatic t_wait(input logic d);
		int n;
		apb(1'b1, A_CF, {30'h0, d, 1'b0});
		cpu.pulse(0);
		@(posedge clk_i);
		chk("imask", {31'h0, imask}, 32'h1);
		chk("clk wait", {30'h0, cpu_en, per_en}, 32'h1);
		chk("wdog wait", {31'h0, wdog}, {31'h0, ~d});
		rdchk("mode wait", `LPRS_OFF_MODE, 32'h1);
		cpu.pulse(2);
		waitfor(1'b0, n);
		chk("wake cycles", n, 1);
		chk("cpu clk back", {31'h0, cpu_en}, 32'h1);
	endtask
	task automatic t_brk();
		int n;
		cpu.pulse(0);
		cpu.pulse(3);
		waitfor(1'b0, n);
		chk("brk wake", n, 1);
		rdchk("bw set", A_BW, 32'h1);
		apb(1'b1, A_BW, 32'h1);
		rdchk("bw w1", A_BW, 32'h1);
		apb(1'b1, A_BW, 32'h0);
		rdchk("bw w0", A_BW, 32'h0);
		cpu.pulse(0);
		cpu.pulse(3);
		waitfor(1'b0, n);
		cpu.pulse(0);
		rpulse(6'h10);
		waitfor(1'b1, n);
		chk("reset exit", n >= REXIT * DIV - DIV && n <= REXIT * DIV + DIV + 2, 1);
		rdchk("bw reset clr", A_BW, 32'h0);
		rdchk("pin flag", A_RS, 32'h40);
		rdchk("src read clr", A_RS, 32'h0);
	endtask
	task automatic t_stop(input logic s, input logic c);
		int n;
		int r;
		r = s ? `LPRS_SHORT_RECOVERY : LREC;
		apb(1'b1, A_CF, {31'h0, s});
		apb(1'b1, A_BF, 32'h80);
		cpu.pulse(1);
		// a counter that runs during stop would end recovery early
		repeat (LREC * DIV + 8) @(posedge clk_i);
		chk("stop clks", {27'h0, cpu_en, per_en, base_en, xtal_en, brk_act}, 32'h0);
		rdchk("mode stop", `LPRS_OFF_MODE, 32'h2);
		if (c)
			rpulse(6'h01);
		else
			cpu.pulse(2);
		waitfor(c, n);
		chk("recovery", n >= r * DIV - DIV && n <= r * DIV + DIV + 2, 1);
		chk("clk out back", {30'h0, base_en, xtal_en}, 32'h3);
		rdchk("flag ctl kept", A_BF, 32'h80);
		if (c)
			rdchk("lvi flag", A_RS, 32'h02);
		apb(1'b1, A_BF, 32'h0);
	endtask
	task automatic t_flags();
		logic [31:0] exp [5] = '{32'h40, 32'h20, 32'h10, 32'h08, 32'h02};
		for (int i = 0; i < 5; i++) begin
			rpulse(6'h10 >> i);
			repeat (REXIT * DIV + 8) @(posedge clk_i);
			rdchk("src flag", A_RS, exp[i]);
		end
		rpulse(6'h10);
		rpulse(6'h30);
		repeat (REXIT * DIV + 8) @(posedge clk_i);
		rdchk("por flag", A_RS, 32'h80);
		rdchk("src clr", A_RS, 32'h0);
	endtask
	task automatic t_protect();
		int n;
		cpu.pulse(0);
		cpu.pulse(3);
		waitfor(1'b0, n);
		cpu.brk(1'b1);
		repeat (2) @(posedge clk_i);
		chk("clr blocked", {31'h0, clr_ok}, 32'h0);
		apb(1'b1, A_BW, 32'h0);
		rdchk("bw protected", A_BW, 32'h1);
		apb(1'b1, A_BF, 32'h80);
		repeat (2) @(posedge clk_i);
		chk("clr allowed", {31'h0, clr_ok}, 32'h1);
		apb(1'b1, A_BW, 32'h0);
		cpu.brk(1'b0);
		apb(1'b1, A_BF, 32'h0);
		rdchk("bw stays clr", A_BW, 32'h0);
	endtask
	task automatic summarize();
		$display("mismatches %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		rst_n_i <= 1'b0;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		pwrite_i <= 1'b0;
		paddr_i <= 8'h00;
		pwdata_i <= 32'h00000000;
		rs <= 6'h00;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_wait(1'b0);
		t_wait(1'b1);
		t_brk();
		t_stop(1'b1, 1'b0);
		t_stop(1'b0, 1'b0);
		t_stop(1'b0, 1'b1);
		t_flags();
		t_protect();
		summarize();
	end
	initial begin
		#200000;
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
